/* design/fcsup_params.svh */
// Constants of the fan control supervisor: offsets, bit positions,
// reset values and parameter defaults.
// Assumes inclusion by bare name from design files.
`ifndef FCSUP_PARAMS_SVH
`define FCSUP_PARAMS_SVH

// Register offsets
`define FCSUP_CTRL_OFFSET 8'h40
`define FCSUP_LOCK_LO 8'h5C
`define FCSUP_LOCK_HI 8'h75

// Field positions in the supervisor control register
`define FCSUP_BIT_START 0
`define FCSUP_BIT_LOCK 1
`define FCSUP_BIT_READY 2
`define FCSUP_BIT_FORCE 3

// Reset and default values
`define FCSUP_CTRL_RST 8'h00
`define FCSUP_DUTY_DEF 8'hFF
`define FCSUP_RANGE_FREQ_DEF 8'hC3
`define FCSUP_ZONE_DISABLED 3'h4

`endif

/* design/fcsup_pkg.sv */
// Types shared by the fan control supervisor modules.
// Assumes fcsup_params.svh is on the include path.
package fcsup_pkg;

  // Supervisor control bits, register bit order
  typedef struct packed {
    logic full_speed_force;
    logic ready;
    logic lock;
    logic start;
  } fcsup_ctrl_t;

  // Per-fan parameter pair selected between programmed and default
  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] range_freq;
  } fcsup_fan_param_t;

endpackage : fcsup_pkg

/* design/fcsup_pwm_gate.sv */
// One fan's PWM output stage: full-speed force, disabled idle level,
// otherwise the generator's waveform.
// Assumes pwm_raw already carries the fan's polarity.
`timescale 1ns/10ps
`include "fcsup_params.svh"

module fcsup_pwm_gate
  import fcsup_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fan controls
  input wire logic pwm_raw,
  input wire logic [2:0] zone_assignment,
  input wire logic pwm_invert,
  input wire logic full_speed_force,
  // Pin drive
  output logic pwm_out
);

  typedef struct packed {
    logic pwm;
  } fcsup_gate_state_t;

  fcsup_gate_state_t st_reg;
  fcsup_gate_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (full_speed_force) begin
      // Force outranks the disabled code
      st_next.pwm = ~pwm_invert;
    end else if (zone_assignment == `FCSUP_ZONE_DISABLED) begin
      st_next.pwm = pwm_invert;
    end else begin
      st_next.pwm = pwm_raw;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_out = st_reg.pwm;

endmodule : fcsup_pwm_gate

/* design/fcsup_top.sv */
// Fan control supervisor register: commit, lock, ready and full-speed
// force, plus the parameter selection and write protection they steer.
// Assumes the serial interface decodes bytes into one-cycle write
// strobes on MCLK and muxes CTRL_RDATA for reads at the control offset.
// Function
// - After commit is written to one, fan control uses the programmed duty and range/frequency values.
// - Before commit is set, programmed values are not moved into the working set and defaults stay.
// - Whenever commit is zero, defaults are used whatever the parameter registers hold.
// - Changing commit never alters the stored limit and parameter registers, only the selection.
// - Commit stays writable whether or not lock is set.
// - Writing lock to one makes the protected parameter registers read-only until power is lost.
// - Lock ignores further writes once set; only power-on reset clears it.
// - Ready is set by hardware after reset and once all converters work; writes do not change it.
// - While full-speed force is one, every PWM output runs at full duty regardless of lock.
// - Full-speed force overrides a fan's disabled setting.
// - While locked, writes to protected registers are dropped and contents kept.
// - A disabled fan drives its PWM output low, or high when inverted, unless forced.
`timescale 1ns/10ps
`include "fcsup_params.svh"

module fcsup_top
  import fcsup_pkg::*;
#(
  parameter int NUM_FANS = 3
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // Register access from the serial interface
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] CTRL_RDATA,
  output logic PARAM_WR_OK,
  // Converter health, asynchronous
  input wire logic ADC_OK,
  // Parameter selection
  input wire fcsup_fan_param_t [NUM_FANS-1:0] PROG_PARAM,
  output fcsup_fan_param_t [NUM_FANS-1:0] EFF_PARAM,
  // PWM output stage
  input wire logic [NUM_FANS-1:0] PWM_RAW,
  input wire logic [NUM_FANS-1:0][2:0] ZONE_ASSIGNMENT,
  input wire logic [NUM_FANS-1:0] PWM_INVERT,
  output logic [NUM_FANS-1:0] PWM_OUT
);

  localparam fcsup_fan_param_t FAN_DEF = '{
    duty: `FCSUP_DUTY_DEF,
    range_freq: `FCSUP_RANGE_FREQ_DEF
  };

  typedef struct packed {
    fcsup_ctrl_t ctrl;
    logic [2:0] adc_sync;
    fcsup_fan_param_t [NUM_FANS-1:0] eff;
  } fcsup_state_t;

  fcsup_state_t st_reg;
  fcsup_state_t st_next;
  fcsup_state_t st_rst;
  fcsup_fan_param_t [NUM_FANS-1:0] eff_def;
  logic ctrl_wr;
  logic in_lock_range;
  logic adc_ok_stable;

  // Refused at elaboration: the struct and the checks assume 1..8 fans
  if (NUM_FANS < 1 || NUM_FANS > 8) begin : g_bad_fans
    $error("fcsup_top: NUM_FANS must lie in 1..8");
  end

  assign eff_def = {NUM_FANS{FAN_DEF}};
  assign ctrl_wr = REG_WR && (REG_ADDR == `FCSUP_CTRL_OFFSET);
  assign in_lock_range = (REG_ADDR >= `FCSUP_LOCK_LO) &&
                         (REG_ADDR <= `FCSUP_LOCK_HI);
  // Second and third stages must agree before the level counts
  assign adc_ok_stable = st_reg.adc_sync[1] & st_reg.adc_sync[2];

  always_comb begin
    st_rst = '0;
    st_rst.ctrl = fcsup_ctrl_t'(4'(`FCSUP_CTRL_RST));
    st_rst.eff = eff_def;
  end

  always_comb begin
    st_next = st_reg;
    st_next.adc_sync = {st_reg.adc_sync[1:0], ADC_OK};
    // Ready is sticky: a converter glitch later must not drop it
    if (adc_ok_stable) begin
      st_next.ctrl.ready = 1'b1;
    end
    if (ctrl_wr) begin
      // Commit and force ignore lock; ready and upper bits ignore data
      st_next.ctrl.start = REG_WDATA[`FCSUP_BIT_START];
      st_next.ctrl.full_speed_force = REG_WDATA[`FCSUP_BIT_FORCE];
      if (REG_WDATA[`FCSUP_BIT_LOCK]) begin
        st_next.ctrl.lock = 1'b1;
      end
    end
    // Selection only; programmed registers live elsewhere, untouched
    if (st_reg.ctrl.start) begin
      st_next.eff = PROG_PARAM;
    end else begin
      st_next.eff = eff_def;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      st_reg <= st_rst;
    end else begin
      st_reg <= st_next;
    end
  end

  // Protected writes are silently dropped once locked
  assign PARAM_WR_OK = REG_WR && in_lock_range && !st_reg.ctrl.lock;
  assign CTRL_RDATA = {4'h0, st_reg.ctrl};
  assign EFF_PARAM = st_reg.eff;

  genvar g;
  generate
    for (g = 0; g < NUM_FANS; g = g + 1) begin : g_fan
      fcsup_pwm_gate u_gate (
        .clk(MCLK),
        .rst_b(RST_B),
        .pwm_raw(PWM_RAW[g]),
        .zone_assignment(ZONE_ASSIGNMENT[g]),
        .pwm_invert(PWM_INVERT[g]),
        .full_speed_force(st_reg.ctrl.full_speed_force),
        .pwm_out(PWM_OUT[g])
      );
    end
  endgenerate

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  logic past_valid;
  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  chk_commit_prog: assert property (
    past_valid && st_reg.ctrl.start |=> EFF_PARAM == $past(PROG_PARAM))
    else $error("working set does not follow programmed values");

  chk_default_held: assert property (
    past_valid && !st_reg.ctrl.start |=> EFF_PARAM == eff_def)
    else $error("defaults not in effect while commit is zero");

  sequence s_commit_write;
    ctrl_wr && REG_WDATA[`FCSUP_BIT_START];
  endsequence

  chk_commit_first_load: assert property (
    !st_reg.ctrl.start ##0 s_commit_write |=> st_reg.ctrl.start
      ##1 EFF_PARAM == $past(PROG_PARAM))
    else $error("commit write did not load programmed values");

  chk_commit_unlocked: assert property (
    st_reg.ctrl.lock && ctrl_wr
      |=> st_reg.ctrl.start == $past(REG_WDATA[`FCSUP_BIT_START]))
    else $error("commit bit not writable while locked");

  chk_lock_sticky: assert property (
    st_reg.ctrl.lock |=> st_reg.ctrl.lock [*8])
    else $error("lock bit cleared after being set");

  chk_lock_blocks: assert property (
    st_reg.ctrl.lock && REG_WR && in_lock_range |-> !PARAM_WR_OK)
    else $error("protected write passed while locked");

  chk_lock_set: assert property (
    ctrl_wr && REG_WDATA[`FCSUP_BIT_LOCK] |=> st_reg.ctrl.lock
      && !(REG_WR && in_lock_range && PARAM_WR_OK))
    else $error("lock write did not protect registers");

  chk_ready_cause: assert property (
    $rose(st_reg.ctrl.ready) |-> $past(adc_ok_stable))
    else $error("ready set without stable converter status");

  chk_force_full: assert property (
    past_valid && st_reg.ctrl.full_speed_force |=>
      PWM_OUT == ~$past(PWM_INVERT))
    else $error("forced outputs not at full duty");

  chk_force_disabled: assert property (
    st_reg.ctrl.full_speed_force &&
      ZONE_ASSIGNMENT[0] == `FCSUP_ZONE_DISABLED
      |=> PWM_OUT[0] == !$past(PWM_INVERT[0]))
    else $error("disabled fan not driven full under force");

  chk_disabled_idle: assert property (
    !st_reg.ctrl.full_speed_force &&
      ZONE_ASSIGNMENT[0] == `FCSUP_ZONE_DISABLED
      |=> PWM_OUT[0] == $past(PWM_INVERT[0]))
    else $error("disabled fan not at idle level");

  chk_reserved_zero: assert property (
    CTRL_RDATA[7:4] == 4'h0 && $past(st_reg.ctrl) == st_reg.ctrl
      || $past(ctrl_wr) || $changed(st_reg.ctrl.ready))
    else $error("reserved bits nonzero or control changed unprompted");

  chk_ready_sticky: assert property (
    st_reg.ctrl.ready |=> st_reg.ctrl.ready)
    else $error("ready flag dropped without reset");

  chk_pwm_follow: assert property (
    !st_reg.ctrl.full_speed_force &&
      ZONE_ASSIGNMENT[NUM_FANS-1] != `FCSUP_ZONE_DISABLED
      |=> PWM_OUT[NUM_FANS-1] == $past(PWM_RAW[NUM_FANS-1]))
    else $error("enabled fan does not follow its generator");

  cov_commit: cover property (s_commit_write ##1 st_reg.ctrl.start);
  cov_lock: cover property ($rose(st_reg.ctrl.lock));
  cov_ready: cover property ($rose(st_reg.ctrl.ready));
  cov_force: cover property ($rose(st_reg.ctrl.full_speed_force));

endmodule : fcsup_top

/* verification/fan_control_supervisor_reg_bench.sv */
// Self-checking bench for the fan control supervisor register.
// Assumes fcsup_top, fcsup_pkg and fcsup_params.svh compiled first.
`timescale 1ns/10ps
`include "fcsup_params.svh"

module fan_control_supervisor_reg_bench import fcsup_pkg::*;;
  localparam logic [47:0] DFLT =
    {3{`FCSUP_DUTY_DEF, `FCSUP_RANGE_FREQ_DEF}};
  localparam logic [7:0] CA = `FCSUP_CTRL_OFFSET;
  localparam logic [47:0] PV1 = 48'h112233445566;
  localparam logic [47:0] PV2 = 48'hA0B1C2D3E4F5;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic adc_ok = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  fcsup_fan_param_t [2:0] prog_param = 48'h000000000000;
  logic [2:0] pwm_raw = 3'h0;
  logic [2:0] pwm_invert = 3'h0;
  logic [2:0][2:0] zone = 9'h000;
  logic [7:0] ctrl_rdata;
  logic param_wr_ok;
  fcsup_fan_param_t [2:0] eff_param;
  logic [2:0] pwm_out;
  int fails = 0;
  int n_checks = 0;
  logic [7:0] addrs [5] = '{8'h5B, 8'h5C, 8'h75, 8'h76, 8'h40};
  logic oks [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  fcsup_top #(.NUM_FANS(3)) i_fcsup_top (
    .MCLK(mclk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .CTRL_RDATA(ctrl_rdata),
    .PARAM_WR_OK(param_wr_ok), .ADC_OK(adc_ok),
    .PROG_PARAM(prog_param), .EFF_PARAM(eff_param),
    .PWM_RAW(pwm_raw), .ZONE_ASSIGNMENT(zone),
    .PWM_INVERT(pwm_invert), .PWM_OUT(pwm_out)
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic test_done;
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : chk

  // Called at a falling edge; returns two falling edges later so the
  // register and everything one stage behind it have settled.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic ok);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    #1;
    chk(param_wr_ok, ok);
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask : wr

  initial begin
    repeat (500) @(posedge mclk);
    fails++;
    test_done;
  end

  initial begin
    @(negedge mclk);
    chk(ctrl_rdata, 8'h00);
    chk(eff_param, DFLT);
    @(negedge mclk);
    rst_b = 1'b1;
    wr(CA, 8'hF4, 1'b0);
    chk(ctrl_rdata, 8'h00);
    prog_param = PV1;
    @(negedge mclk);
    chk(eff_param, DFLT);
    // Data zero so the control write in the table changes nothing
    for (int i = 0; i < 5; i++) begin
      wr(addrs[i], 8'h00, oks[i]);
    end
    adc_ok = 1'b1;
    repeat (6) @(negedge mclk);
    chk(ctrl_rdata, 8'h04);
    wr(CA, 8'h01, 1'b0);
    chk(ctrl_rdata, 8'h05);
    chk(eff_param, PV1);
    prog_param = PV2;
    @(negedge mclk);
    chk(eff_param, PV2);
    wr(CA, 8'h00, 1'b0);
    chk(eff_param, DFLT);
    // Converter drops; ready must stay set
    adc_ok = 1'b0;
    pwm_raw = 3'b101;
    zone = {3'h0, `FCSUP_ZONE_DISABLED, `FCSUP_ZONE_DISABLED};
    pwm_invert = 3'b010;
    @(negedge mclk);
    chk(pwm_out, 3'b110);
    wr(CA, 8'h08, 1'b0);
    chk(ctrl_rdata, 8'h0C);
    chk(pwm_out, 3'b101);
    wr(CA, 8'h03, 1'b0);
    chk(ctrl_rdata, 8'h07);
    chk(pwm_out, 3'b110);
    wr(8'h5C, 8'h00, 1'b0);
    wr(CA, 8'h00, 1'b0);
    chk(ctrl_rdata, 8'h06);
    wr(CA, 8'h09, 1'b0);
    chk(ctrl_rdata, 8'h0F);
    chk(eff_param, PV2);
    chk(pwm_out, 3'b101);
    // Only a reset may clear the lock
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    chk(ctrl_rdata, 8'h00);
    chk(eff_param, DFLT);
    chk(pwm_out, 3'b000);
    rst_b = 1'b1;
    wr(8'h5C, 8'h00, 1'b1);
    test_done;
  end
endmodule : fan_control_supervisor_reg_bench
